/* File: lhb_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - hardware mode: pin is template select lsb
// - serial input sampled on shift clock rise
// - write strobe rise captures eight bus bits
// - data strobe rise, write select captures bus
// - data strobe read drives read data
// - non-muxed: address latched on strobe fall in data strobe mode only
// - output edge select picks shift-out edge
// - read: output high-z during command byte
// - ready low demands host wait states
// - acknowledge low: read valid or write taken
// - open-drain low interrupt from four sources
// - loop pins select remote, none, analog
// - muxed address from low five bus bits
// - muxed pins shared; grounded in serial mode
module lhb_host_port
  import lhb_pkg::*;
(
  // clocks and reset
  input  wire logic                      mclk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      sclk_in,
  // mode straps
  input  wire logic [1:0]                host_mode_in,
  input  wire logic                      muxed_in,
  // serial host pins
  input  wire logic                      sdi_in,
  input  wire logic                      out_edge_select_in,
  output logic                           serial_out_out,
  output logic                           serial_out_oe_out,
  // parallel host pins
  input  wire logic                      data_strobe_n_in,
  input  wire logic                      rd_rw_in,
  input  wire logic                      address_strobe_n_in,
  input  wire logic [ADDR_W-1:0]         addr_in,
  input  wire logic [DATA_W-1:0]         bus_in,
  output logic [DATA_W-1:0]              bus_out,
  output logic                           bus_oe_out,
  output logic                           ready_out,
  output logic                           ack_n_out,
  // interrupt pin
  input  wire logic [IRQ_SOURCES-1:0]    irq_src_in,
  output logic                           int_n_out,
  output logic                           int_n_oe_out,
  // hardware control pins
  input  wire logic [1:0]                tmpl_hi_in,
  input  wire logic [2*CHANNELS-1:0]     loop_select_in,
  output logic [TMPL_W-1:0]              template_sel_out,
  output logic [CHANNELS-1:0]            loop_remote_out,
  output logic [CHANNELS-1:0]            loop_analog_out,
  // internal register access
  output logic [ADDR_W-1:0]              reg_addr_out,
  output logic [DATA_W-1:0]              reg_wdata_out,
  output logic                           reg_wr_out,
  output logic                           reg_rd_out,
  input  wire logic [DATA_W-1:0]         reg_rdata_in
);
  import lhb_pkg::*;

  // ****************************************
  // pin synchronisers (mclk)
  // ****************************************
  localparam int SW = 6 + ADDR_W + DATA_W + 2 + 2*CHANNELS;
  logic [SW-1:0]     sync1;
  logic [SW-1:0]     sync2;
  logic [2:0]        stb3;
  logic              stb2;
  logic              rdrw2;
  logic              lat2;
  logic              mux2;
  lhb_mode_type      mode;
  logic [ADDR_W-1:0] apin2;
  logic [DATA_W-1:0] bus2;
  logic [1:0]        thi2;
  logic [2*CHANNELS-1:0] loop2;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // strobe bits start at their idle high level: no false edge after reset
      sync1 <= {3'h7, {(SW-3){1'b0}}};
      sync2 <= {3'h7, {(SW-3){1'b0}}};
      stb3  <= 3'h7;
    end else begin
      sync1 <= {data_strobe_n_in, rd_rw_in, address_strobe_n_in, muxed_in,
                host_mode_in, addr_in, bus_in, tmpl_hi_in, loop_select_in};
      sync2 <= sync1;
      stb3  <= {stb2, rdrw2, lat2};
    end
  end

  assign {stb2, rdrw2, lat2, mux2} = sync2[SW-1 -: 4];
  assign mode  = lhb_mode_type'(sync2[SW-5 -: 2]);
  assign apin2 = sync2[SW-7 -: ADDR_W];
  assign bus2  = sync2[SW-7-ADDR_W -: DATA_W];
  assign thi2  = sync2[2*CHANNELS+1 -: 2];
  assign loop2 = sync2[2*CHANNELS-1:0];

  logic stb_rise;
  logic stb_fall;
  logic rd_fall;
  logic rd_rise;
  logic lat_rise;
  logic lat_fall;
  assign stb_rise = stb2 & ~stb3[2];
  assign stb_fall = ~stb2 & stb3[2];
  assign rd_fall  = ~rdrw2 & stb3[1];
  assign rd_rise  = rdrw2 & ~stb3[1];
  assign lat_rise = lat2 & ~stb3[0];
  assign lat_fall = ~lat2 & stb3[0];

  // ****************************************
  // serial link (sclk domain)
  // ****************************************
  logic [3:0]        bit_cnt;
  logic [6:0]        shin;
  logic              cmd_rw;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] ser_wdata;
  logic              rreq_t;
  logic              wreq_t;
  logic [1:0]        sen_s;
  logic [1:0]        edge_s;
  logic              ser_oe;
  logic              sdo_rise;
  logic              sdo_fall;
  logic [DATA_W-1:0] ser_rdata;

  always_ff @(posedge sclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sen_s  <= 2'h0;
      edge_s <= 2'h0;
    end else begin
      sen_s  <= {sen_s[0], mode == LHB_SER};
      edge_s <= {edge_s[0], out_edge_select_in};
    end
  end

  always_ff @(posedge sclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt   <= 4'h0;
      shin      <= 7'h00;
      cmd_rw    <= 1'b0;
      cmd_addr  <= '0;
      ser_wdata <= '0;
      rreq_t    <= 1'b0;
      wreq_t    <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      shin    <= {shin[5:0], sdi_in};
      if (bit_cnt == SER_CMD_LAST) begin
        cmd_rw   <= shin[SER_RW_POS];
        cmd_addr <= {shin[3:0], sdi_in};
        if (shin[SER_RW_POS]) begin
          rreq_t <= ~rreq_t;
        end
      end
      if (bit_cnt == SER_DATA_LAST && !cmd_rw) begin
        ser_wdata <= {shin, sdi_in};
        wreq_t    <= ~wreq_t;
      end
    end
  end

  // enable moves on falling edges so it outlasts the last bit on either edge
  always_ff @(negedge sclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ser_oe <= 1'b0;
    end else if (bit_cnt == SER_CMD_LAST + 4'h1) begin
      ser_oe <= cmd_rw & sen_s[1];
    end else if (bit_cnt == 4'h0) begin
      ser_oe <= 1'b0;
    end
  end

  // ser_rdata is held stable by the mclk side well before the data byte
  always_ff @(posedge sclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sdo_rise <= 1'b0;
    end else if (bit_cnt[3]) begin
      sdo_rise <= ser_rdata[~bit_cnt[2:0]];
    end else begin
      sdo_rise <= 1'b0;
    end
  end

  always_ff @(negedge sclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sdo_fall <= 1'b0;
    end else begin
      sdo_fall <= bit_cnt[3] ? ser_rdata[~bit_cnt[2:0]] : 1'b0;
    end
  end

  assign serial_out_out    = edge_s[1] ? sdo_fall : sdo_rise;
  assign serial_out_oe_out = ser_oe;

  // ****************************************
  // serial request crossing (mclk)
  // ****************************************
  logic [2:0] rreq_s;
  logic [2:0] wreq_s;
  logic       ser_rd_ev;
  logic       ser_wr_ev;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rreq_s <= 3'h0;
      wreq_s <= 3'h0;
    end else begin
      rreq_s <= {rreq_s[1:0], rreq_t};
      wreq_s <= {wreq_s[1:0], wreq_t};
    end
  end

  assign ser_rd_ev = (rreq_s[2] ^ rreq_s[1]) && mode == LHB_SER;
  assign ser_wr_ev = (wreq_s[2] ^ wreq_s[1]) && mode == LHB_SER;

  // ****************************************
  // parallel cycle decode (mclk)
  // ****************************************
  logic [ADDR_W-1:0] addr_l;
  logic [ADDR_W-1:0] par_addr;
  logic              par_rd_ev;
  logic              par_wr_ev;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_l <= '0;
    end else if (mux2 && mode == LHB_STB && lat_fall) begin
      addr_l <= bus2[ADDR_W-1:0];
    end else if (mux2 && mode == LHB_DST && lat_rise) begin
      addr_l <= bus2[ADDR_W-1:0];
    end else if (!mux2 && mode == LHB_DST && stb_fall) begin
      addr_l <= apin2;
    end
  end

  always_comb begin
    par_addr = apin2;
    if (mux2 || (mode == LHB_DST && !stb_fall)) begin
      par_addr = addr_l;
    end
  end

  // rd_rw pin is the read strobe or the read/write select by mode
  assign par_rd_ev = (mode == LHB_STB && rd_fall) ||
                     (mode == LHB_DST && stb_fall && rdrw2);
  assign par_wr_ev = (mode == LHB_STB && stb_rise) ||
                     (mode == LHB_DST && stb_rise && !rdrw2);

  // ****************************************
  // register access
  // ****************************************
  logic rd_pend;
  logic par_pend;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_addr_out  <= '0;
      reg_wdata_out <= '0;
      reg_wr_out    <= 1'b0;
      reg_rd_out    <= 1'b0;
    end else begin
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      if (ser_wr_ev) begin
        reg_addr_out  <= cmd_addr;
        reg_wdata_out <= ser_wdata;
        reg_wr_out    <= 1'b1;
      end else if (ser_rd_ev) begin
        reg_addr_out <= cmd_addr;
        reg_rd_out   <= 1'b1;
      end else if (par_wr_ev) begin
        reg_addr_out  <= par_addr;
        reg_wdata_out <= bus2;
        reg_wr_out    <= 1'b1;
      end else if (par_rd_ev) begin
        reg_addr_out <= par_addr;
        reg_rd_out   <= 1'b1;
      end
    end
  end

  // read data is taken the cycle after the read pulse
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_pend   <= 1'b0;
      par_pend  <= 1'b0;
      ser_rdata <= '0;
    end else begin
      rd_pend  <= reg_rd_out;
      par_pend <= reg_rd_out && mode != LHB_SER;
      if (rd_pend && !par_pend) begin
        ser_rdata <= reg_rdata_in;
      end
    end
  end

  // ****************************************
  // parallel bus drive and handshake
  // ****************************************
  logic rd_busy;
  logic data_ok;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_out    <= '0;
      bus_oe_out <= 1'b0;
      rd_busy    <= 1'b0;
      data_ok    <= 1'b0;
    end else begin
      if (par_rd_ev) begin
        rd_busy <= 1'b1;
      end else if (par_pend) begin
        rd_busy <= 1'b0;
      end
      if (mode == LHB_HW || mode == LHB_SER) begin
        bus_oe_out <= 1'b0;
        data_ok    <= 1'b0;
      end else if ((mode == LHB_STB && rd_rise) ||
                   (mode == LHB_DST && stb_rise)) begin
        bus_oe_out <= 1'b0;
        data_ok    <= 1'b0;
      end else if (par_pend) begin
        bus_out    <= reg_rdata_in;
        bus_oe_out <= 1'b1;
        data_ok    <= 1'b1;
      end
    end
  end

  // ready is sampled late by the strobe synchroniser; see host timing
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ready_out <= 1'b1;
      ack_n_out <= 1'b1;
    end else begin
      ready_out <= !(mode == LHB_STB && (rd_busy || par_rd_ev));
      ack_n_out <= !(mode == LHB_DST && !stb2 && !stb_fall &&
                     (data_ok || !rdrw2));
    end
  end

  // ****************************************
  // interrupt and hardware control
  // ****************************************
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      int_n_out    <= 1'b0;
      int_n_oe_out <= 1'b0;
    end else begin
      int_n_out    <= 1'b0;
      int_n_oe_out <= |irq_src_in;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      template_sel_out <= '0;
      loop_remote_out  <= '0;
      loop_analog_out  <= '0;
    end else if (mode == LHB_HW) begin
      template_sel_out <= {thi2, stb2};
      for (int i = 0; i < CHANNELS; i++) begin
        loop_remote_out[i] <= loop2[2*i +: 2] == LOOP_LOW;
        loop_analog_out[i] <= loop2[2*i +: 2] == LOOP_HIGH;
      end
    end
  end

endmodule
`default_nettype wire

/* File: lhb_host_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module lhb_mon
  import lhb_pkg::*;
(
  // clock, reset and straps
  input wire logic                   mclk_in,
  input wire logic                   sys_rst_in,
  input wire logic [1:0]             host_mode_in,
  // host pins
  input wire logic                   data_strobe_n_in,
  input wire logic                   rd_rw_in,
  input wire logic [1:0]             tmpl_hi_in,
  input wire logic [IRQ_SOURCES-1:0] irq_src_in,
  // outputs watched
  input wire logic [TMPL_W-1:0]      template_sel_out,
  input wire logic                   int_n_out,
  input wire logic                   int_n_oe_out,
  input wire logic                   ready_out,
  input wire logic                   ack_n_out,
  input wire logic                   bus_oe_out,
  input wire logic                   serial_out_oe_out,
  input wire logic                   reg_wr_out,
  input wire logic                   reg_rd_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // ******
  // strobe-mode read: wait states, then data
  // ******
  sequence s_rd_start;
    host_mode_in == LHB_STB && $fell(rd_rw_in);
  endsequence
  sequence s_wait_go;
    ##[2:5] !ready_out ##[1:8] (ready_out && bus_oe_out);
  endsequence
  a_ready_wait: assert property (s_rd_start |-> s_wait_go)
    else $error("ready did not wait then release");
  a_irq_or: assert property (1'b1 |=> int_n_oe_out == (|$past(irq_src_in)))
    else $error("interrupt enable not the or of sources");
  a_int_low: assert property (int_n_oe_out |-> !int_n_out)
    else $error("interrupt pin not pulled low");
  a_tmpl_lsb: assert property ((host_mode_in == LHB_HW && $stable(data_strobe_n_in)
    && $stable(tmpl_hi_in))[*5] |-> template_sel_out == {tmpl_hi_in, data_strobe_n_in})
    else $error("template select wrong");
  a_ack_write: assert property (host_mode_in == LHB_DST && !rd_rw_in
    && $fell(data_strobe_n_in) |-> ##[1:5] !ack_n_out)
    else $error("write not acknowledged");
  a_ack_read: assert property (host_mode_in == LHB_DST && reg_rd_out
    |-> ##[1:4] (!ack_n_out && bus_oe_out))
    else $error("read data not acknowledged");
  a_ready_idle: assert property ((host_mode_in != LHB_STB)[*4] |-> ready_out)
    else $error("ready low outside strobe mode");
  a_ack_idle: assert property ((host_mode_in != LHB_DST)[*4] |-> ack_n_out)
    else $error("acknowledge low outside its mode");
  a_sdo_quiet: assert property ((host_mode_in != LHB_SER)[*4] |-> !serial_out_oe_out)
    else $error("serial output driven outside serial mode");
  a_wr_pulse: assert property (reg_wr_out |=> !reg_wr_out)
    else $error("write pulse longer than one cycle");
endmodule
bind lhb_host_port lhb_mon mon_u (.mclk_in, .sys_rst_in, .host_mode_in, .data_strobe_n_in,
  .rd_rw_in, .tmpl_hi_in, .irq_src_in, .template_sel_out, .int_n_out, .int_n_oe_out,
  .ready_out, .ack_n_out, .bus_oe_out, .serial_out_oe_out, .reg_wr_out, .reg_rd_out);
`default_nettype wire

/* File: lhb_pkg.sv */
package lhb_pkg;
  // ****************************************
  // host port modes (strap pins)
  // ****************************************
  typedef enum logic [1:0] {
    LHB_HW  = 2'h0,
    LHB_SER = 2'h1,
    LHB_STB = 2'h3,
    LHB_DST = 2'h2
  } lhb_mode_type;

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int ADDR_W      = 5;
  localparam int DATA_W      = 8;
  localparam int CHANNELS    = 8;
  localparam int IRQ_SOURCES = 4;
  localparam int TMPL_W      = 3;
  // serial frame: command byte then data byte, msb first
  localparam logic [3:0] SER_CMD_LAST  = 4'h7;
  localparam logic [3:0] SER_DATA_LAST = 4'hf;
  localparam int         SER_RW_POS    = 6;
  // three-level loop pin as seen after its level detector
  localparam logic [1:0] LOOP_LOW  = 2'h0;
  localparam logic [1:0] LOOP_MID  = 2'h1;
  localparam logic [1:0] LOOP_HIGH = 2'h2;
endpackage

/* File: lhb_ser_host.sv */
`timescale 1ns/1ps
`default_nettype none
module lhb_ser_host (
  // serial pins
  output logic      sclk_out,
  output logic      sdi_out,
  input  wire logic es_in,
  input  wire logic so_in,
  input  wire logic oe_in
);
  // one edge inside reset so the far bit counter starts clean
  initial begin
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    #30 sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
  end
  // ******
  // frame: clock stands low between frames
  // ******
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd, output logic zerr);
    int i;
    zerr = 1'b0;
    rd = 8'h00;
    for (i = 0; i < 16; i++) begin
      sdi_out = f[15-i];
      #40;
      if (oe_in && (i < 8 || !f[15])) zerr = 1'b1;
      if (!oe_in && i > 7 && f[15]) zerr = 1'b1;
      if (es_in && i > 7) rd = {rd[6:0], oe_in ? so_in : 1'bx};
      sclk_out = 1'b1;
      #40;
      // pause lets the read cross into the system clock
      if (i == 7) #300;
      if (!es_in && i > 7) rd = {rd[6:0], oe_in ? so_in : 1'bx};
      sclk_out = 1'b0;
    end
    sdi_out = ~sdi_out;
  endtask
endmodule
`default_nettype wire

/* File: tb_lhb_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_lhb_host_port;
  import lhb_pkg::*;
  logic        mclk_in, sys_rst_in, sclk, sdi, es, ds_n, rw, so, soe, boe, rdy, ack_n;
  logic        intn, inoe, rwr, rrd, z, mx, as_n;
  logic [1:0]  mode, thi;
  logic [2:0]  tsel;
  logic [3:0]  irq;
  logic [4:0]  addr, ra, wa;
  logic [7:0]  bus, bout, rwd, wd, rd, lrem, lana;
  logic [15:0] lsel;
  int          n;
  int          error_cnt = 0;
  int          cmp_count = 0;
  lhb_host_port dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk),
    .host_mode_in(mode), .muxed_in(mx), .sdi_in(sdi), .out_edge_select_in(es),
    .serial_out_out(so), .serial_out_oe_out(soe), .data_strobe_n_in(ds_n), .rd_rw_in(rw),
    .address_strobe_n_in(as_n), .addr_in(addr), .bus_in(bus), .bus_out(bout),
    .bus_oe_out(boe), .ready_out(rdy), .ack_n_out(ack_n), .irq_src_in(irq),
    .int_n_out(intn), .int_n_oe_out(inoe), .tmpl_hi_in(thi), .loop_select_in(lsel),
    .template_sel_out(tsel), .loop_remote_out(lrem), .loop_analog_out(lana),
    .reg_addr_out(ra), .reg_wdata_out(rwd), .reg_wr_out(rwr), .reg_rd_out(rrd),
    .reg_rdata_in({ra, 3'h6}));
  lhb_ser_host host_u (.sclk_out(sclk), .sdi_out(sdi), .es_in(es), .so_in(so), .oe_in(soe));
  always @(posedge mclk_in) if (rwr) begin
    wa <= ra;
    wd <= rwd;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk_in);
    #2;
  endtask
  task wack;
    n = 0;
    while (ack_n !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
  endtask
  task t_hw;
    for (int c = 0; c < 8; c++) lsel[2*c +: 2] = 2'(c % 3);
    thi = 2'h2;
    cyc(8);
    chk({5'h0, tsel}, 8'h05);
    chk(lrem, 8'h49);
    chk(lana, 8'h24);
    ds_n = 1'b0;
    cyc(8);
    chk({5'h0, tsel}, 8'h04);
    $display("t_hw done");
  endtask
  task t_irq;
    for (int i = 0; i < 4; i++) begin
      irq = 4'(1 << i);
      cyc(2);
      chk({6'h0, intn, inoe}, 8'h01);
      irq = 4'h0;
      cyc(2);
      chk({6'h0, intn, inoe}, 8'h00);
    end
    $display("t_irq done");
  endtask
  task t_ser;
    mode = LHB_SER;
    ds_n = 1'b1;
    bus = 8'h00;
    cyc(6);
    host_u.xfer(16'h0ba5, rd, z);
    cyc(6);
    chk({3'h0, wa}, 8'h0b);
    chk(wd, 8'ha5);
    chk({7'h0, z}, 8'h00);
    for (int e = 0; e < 2; e++) begin
      es = e[0];
      cyc(4);
      host_u.xfer(16'hf300, rd, z);
      chk(rd, {5'h13, 3'h6});
      chk({7'h0, z}, 8'h00);
      cyc(4);
    end
    $display("t_ser done");
  endtask
  task t_stb;
    mode = LHB_STB;
    cyc(6);
    addr = 5'h1e;
    bus = 8'h5a;
    ds_n = 1'b0;
    cyc(4);
    ds_n = 1'b1;
    cyc(4);
    bus = 8'hff;
    cyc(4);
    chk({3'h0, wa}, 8'h1e);
    chk(wd, 8'h5a);
    addr = 5'h07;
    rw = 1'b0;
    n = 0;
    repeat (12) begin
      cyc(1);
      if (rdy === 1'b0) n++;
    end
    chk({7'h0, n != 0}, 8'h01);
    chk(bout, {5'h07, 3'h6});
    chk({7'h0, boe & rdy}, 8'h01);
    rw = 1'b1;
    cyc(6);
    $display("t_stb done");
  endtask
  task t_mux;
    mx = 1'b1;
    bus = 8'hf4;
    cyc(4);
    as_n = 1'b0;
    cyc(4);
    as_n = 1'b1;
    bus = 8'h3c;
    ds_n = 1'b0;
    cyc(4);
    ds_n = 1'b1;
    cyc(6);
    chk({3'h0, wa}, 8'h14);
    chk(wd, 8'h3c);
    mode = LHB_DST;
    cyc(6);
    bus = 8'he9;
    as_n = 1'b0;
    cyc(4);
    as_n = 1'b1;
    cyc(4);
    rw = 1'b0;
    bus = 8'h77;
    ds_n = 1'b0;
    wack;
    chk({7'h0, ack_n}, 8'h00);
    ds_n = 1'b1;
    cyc(6);
    chk({3'h0, wa}, 8'h09);
    chk(wd, 8'h77);
    rw = 1'b1;
    mx = 1'b0;
    cyc(4);
    $display("t_mux done");
  endtask
  task t_dst;
    mode = LHB_DST;
    cyc(6);
    rw = 1'b0;
    addr = 5'h15;
    bus = 8'hc3;
    ds_n = 1'b0;
    wack;
    chk({7'h0, ack_n}, 8'h00);
    addr = 5'h02;
    ds_n = 1'b1;
    cyc(4);
    chk({3'h0, wa}, 8'h15);
    chk(wd, 8'hc3);
    rw = 1'b1;
    cyc(2);
    ds_n = 1'b0;
    wack;
    chk(bout, {5'h02, 3'h6});
    chk({7'h0, boe}, 8'h01);
    ds_n = 1'b1;
    cyc(6);
    $display("t_dst done");
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    sys_rst_in = 1'b1;
    {mode, thi, ds_n, rw, es, as_n, mx, addr, bus, irq, lsel} = {LHB_HW, 2'h0, 5'h1a, 5'h0, 28'h0};
    repeat (4) @(posedge mclk_in);
    #2 sys_rst_in = 1'b0;
    cyc(4);
    t_hw;
    t_irq;
    t_ser;
    t_stb;
    t_mux;
    t_dst;
    results;
  end
  // generous: the whole sequence needs well under 20 us
  initial begin
    #200000;
    error_cnt++;
    results;
  end
endmodule
`default_nettype wire
